/* File: src/iru_pkg.sv */
// constants, types and register layout of the interrupt redirection unit
package iru_pkg;
    // memory-mapped ports
    localparam logic [31:0] SEL_ADDR = 32'hfec0_0000;
    localparam logic [31:0] DATA_ADDR = 32'hfec0_0010;
    localparam logic [3:0] BE_ALL = 4'hf;
    // selector values
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] IDX_ID = 8'h00;
    localparam logic [7:0] IDX_VER = 8'h01;
    localparam logic [7:0] IDX_ARB = 8'h02;
    localparam logic [7:0] IDX_RED_LO = 8'h10;
    localparam logic [7:0] IDX_RED_HI = 8'h3f;
    // entry count and widths
    localparam int NUM_ENT = 24;
    localparam int ENT_W = 5;
    localparam int WORD_W = 6;
    // identifier field in words 00h and 02h
    localparam int ID_LSB = 24;
    localparam int ID_W = 4;
    localparam logic [ID_W-1:0] ID_RESET = 4'h0;
    // version word; value arbitrary
    localparam logic [31:0] VERSION_VAL = 32'h0000_0a01;
    // entry reset values and writable bits per half
    localparam logic [31:0] LO_RESET = 32'h0001_0000;
    localparam logic [31:0] HI_RESET = 32'h0000_0000;
    localparam logic [31:0] LO_WMASK = 32'h0001_afff;
    localparam logic [31:0] HI_WMASK = 32'hff00_0000;
    // field positions in the low half
    localparam int B_MASK = 16;
    localparam int B_TRIG = 15;
    localparam int B_IRR = 14;
    localparam int B_POL = 13;
    localparam int B_PEND = 12;
    localparam int B_DMODE = 11;
    localparam int MODE_LSB = 8;
    localparam int VEC_LSB = 0;
    // destination field in the high half
    localparam int DEST_LSB = 24;
    // delivery type codes
    localparam logic [2:0] MODE_FIXED = 3'h0;
    localparam logic [2:0] MODE_LOWEST = 3'h1;
    localparam logic [2:0] MODE_SMI = 3'h2;
    localparam logic [2:0] MODE_RSV0 = 3'h3;
    localparam logic [2:0] MODE_NMI = 3'h4;
    localparam logic [2:0] MODE_INIT = 3'h5;
    localparam logic [2:0] MODE_RSV1 = 3'h6;
    localparam logic [2:0] MODE_EXTERNAL_CONTROLLER_DELIVERY = 3'h7;

    typedef enum {IRU_IDLE, IRU_WAIT, IRU_SEND} iru_dlv_state_t;

    // outgoing interrupt message
    typedef struct packed {
        logic [7:0] dest;
        logic dest_logical;
        logic [2:0] mode;
        logic level;
        logic [7:0] vector;
    } iru_msg_t;
endpackage

/* File: src/iru_entry_mem.sv */
// redirection entry storage with registered read port
`timescale 1ns/1ps
`default_nettype none
module iru_entry_mem (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic [iru_pkg::WORD_W-1:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [iru_pkg::ENT_W-1:0] raddr_i,
    output logic [63:0] rdata_o,
    output logic [iru_pkg::NUM_ENT-1:0] mask_o,
    output logic [iru_pkg::NUM_ENT-1:0] trig_o,
    output logic [iru_pkg::NUM_ENT-1:0] pol_o,
    output logic [iru_pkg::NUM_ENT*8-1:0] vec_o
);
    logic [31:0] words_q [2*iru_pkg::NUM_ENT];
    logic [31:0] wmask;

    assign wmask = waddr_i[0] ? iru_pkg::HI_WMASK : iru_pkg::LO_WMASK;

    // word store; status bits and reserved bits never stored
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 2*iru_pkg::NUM_ENT; i++) begin
                words_q[i] <= (i % 2 == 1) ? iru_pkg::HI_RESET : iru_pkg::LO_RESET;
            end
        end else if (we_i) begin
            words_q[waddr_i] <= (words_q[waddr_i] & ~wmask) | (wdata_i & wmask);
        end
    end

    // full 64-bit entry read, one cycle latency
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 64'h0;
        end else begin
            rdata_o <= {words_q[{raddr_i, 1'b1}], words_q[{raddr_i, 1'b0}]};
        end
    end

    // control fields the detection logic needs for every entry
    always_comb begin
        for (int i = 0; i < iru_pkg::NUM_ENT; i++) begin
            mask_o[i] = words_q[2*i][iru_pkg::B_MASK];
            trig_o[i] = words_q[2*i][iru_pkg::B_TRIG];
            pol_o[i] = words_q[2*i][iru_pkg::B_POL];
            vec_o[i*8 +: 8] = words_q[2*i][iru_pkg::VEC_LSB +: 8];
        end
    end
endmodule
`default_nettype wire

/* File: src/iru_top.sv */
// interrupt redirection unit: indexed register access and message delivery
`timescale 1ns/1ps
`default_nettype none
module iru_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] addr_i,
    input wire logic [3:0] be_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    input wire logic [iru_pkg::NUM_ENT-1:0] irq_i,
    input wire logic eoi_valid_i,
    input wire logic [7:0] eoi_vector_i,
    output logic msg_valid_o,
    input wire logic msg_ready_i,
    output var iru_pkg::iru_msg_t msg_o
);
    localparam int N = iru_pkg::NUM_ENT;

    // lowest set bit wins the delivery scan
    function automatic logic [iru_pkg::ENT_W-1:0] first_set(input logic [N-1:0] v);
        logic [iru_pkg::ENT_W-1:0] r;
        r = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i[iru_pkg::ENT_W-1:0];
            end
        end
        return r;
    endfunction

    // selector value names a redirection word
    function automatic logic is_entry(input logic [7:0] s);
        return (s >= iru_pkg::IDX_RED_LO) && (s <= iru_pkg::IDX_RED_HI);
    endfunction

    logic [7:0] sel_q;
    logic [iru_pkg::ID_W-1:0] id_q;
    logic [N-1:0] sync1_q, sync2_q, prev_q, pend_q, irr_q;
    logic [N-1:0] mask, trig, pol, asserted, set_edge, set_lvl, eoi_hit, pend_clr, ready_set;
    logic [N*8-1:0] vec;
    logic [63:0] mem_rdata;
    logic sel_wr, data_wr, bus_rd, mem_we;
    logic [7:0] sel_off;
    logic [iru_pkg::ENT_W-1:0] raddr, dlv_idx_q;
    logic rd_q, rd_ent_q, rd_hi_q;
    logic [iru_pkg::ENT_W-1:0] rd_idx_q;
    logic [31:0] rd_direct_q, lo_view;
    iru_pkg::iru_dlv_state_t st_q;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    // selector and data port decode
    assign sel_wr = wr_i && (addr_i == iru_pkg::SEL_ADDR) && be_i[0];
    assign data_wr = wr_i && (addr_i == iru_pkg::DATA_ADDR) && (be_i == iru_pkg::BE_ALL);
    assign bus_rd = rd_i && !wr_i;
    assign sel_off = sel_q - iru_pkg::IDX_RED_LO;
    assign mem_we = data_wr && is_entry(sel_q);

    // selector register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_q <= iru_pkg::SEL_RESET;
        end else if (sel_wr) begin
            sel_q <= wdata_i[7:0];
        end
    end

    // identifier register, only bits 27:24 held
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            id_q <= iru_pkg::ID_RESET;
        end else if (data_wr && sel_q == iru_pkg::IDX_ID) begin
            id_q <= wdata_i[iru_pkg::ID_LSB +: iru_pkg::ID_W];
        end
    end

    // memory read port: bus reads take priority over the delivery scan
    assign raddr = (bus_rd && is_entry(sel_q)) ? sel_off[iru_pkg::ENT_W:1]
                                               : first_set(ready_set);

    iru_entry_mem u_mem (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(mem_we),
        .waddr_i(sel_off[iru_pkg::WORD_W-1:0]),
        .wdata_i(wdata_i),
        .raddr_i(raddr),
        .rdata_o(mem_rdata),
        .mask_o(mask),
        .trig_o(trig),
        .pol_o(pol),
        .vec_o(vec)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path, two cycles from request to data
    // first stage: capture what is being read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= 1'b0;
            rd_ent_q <= 1'b0;
            rd_hi_q <= 1'b0;
            rd_idx_q <= '0;
            rd_direct_q <= 32'h0;
        end else begin
            rd_q <= bus_rd;
            rd_ent_q <= bus_rd && (addr_i == iru_pkg::DATA_ADDR) && is_entry(sel_q);
            rd_hi_q <= sel_q[0];
            rd_idx_q <= sel_off[iru_pkg::ENT_W:1];
            rd_direct_q <= 32'h0;
            if (addr_i == iru_pkg::SEL_ADDR) begin
                rd_direct_q <= {24'h0, sel_q};
            end else if (addr_i == iru_pkg::DATA_ADDR) begin
                case (sel_q)
                    iru_pkg::IDX_ID: rd_direct_q <= {4'h0, id_q, 24'h0};
                    iru_pkg::IDX_VER: rd_direct_q <= iru_pkg::VERSION_VAL;
                    iru_pkg::IDX_ARB: rd_direct_q <= {4'h0, id_q, 24'h0};
                    default: rd_direct_q <= 32'h0;
                endcase
            end
        end
    end

    // live status bits patched into the lower half
    always_comb begin
        lo_view = mem_rdata[31:0];
        lo_view[iru_pkg::B_IRR] = irr_q[rd_idx_q];
        lo_view[iru_pkg::B_PEND] = pend_q[rd_idx_q];
    end

    // second stage: read data out
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0;
        end else begin
            rvalid_o <= rd_q;
            rdata_o <= rd_ent_q ? (rd_hi_q ? mem_rdata[63:32] : lo_view) : rd_direct_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input detection
    // pin synchroniser
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= irq_i;
            sync2_q <= sync1_q;
        end
    end

    // polarity folds the input to active high
    assign asserted = sync2_q ^ pol;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= asserted;
        end
    end

    // edge entries catch rises, level entries the level
    assign set_edge = asserted & ~prev_q & ~trig & ~mask;
    // level request sets receipt and pending
    assign set_lvl = asserted & trig & ~mask & ~irr_q & ~pend_q;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            eoi_hit[i] = eoi_valid_i && trig[i] && (vec[i*8 +: 8] == eoi_vector_i);
        end
    end

    // receipt flags; a new request beats the clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irr_q <= '0;
        end else begin
            irr_q <= (irr_q & ~eoi_hit) | set_lvl;
        end
    end

    // pending flags; a new event beats the clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~pend_clr) | set_edge | set_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delivery
    // masked entries stay out of the scan
    assign ready_set = pend_q & ~mask;

    always_comb begin
        pend_clr = '0;
        if (st_q == iru_pkg::IRU_SEND && msg_ready_i) begin
            pend_clr[dlv_idx_q] = 1'b1;
        end else if (st_q == iru_pkg::IRU_WAIT && (mem_rdata[iru_pkg::MODE_LSB +: 3] ==
                     iru_pkg::MODE_RSV0 || mem_rdata[iru_pkg::MODE_LSB +: 3] ==
                     iru_pkg::MODE_RSV1)) begin
            pend_clr[dlv_idx_q] = 1'b1;
        end
    end

    // scan, fetch entry, hold message until taken
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= iru_pkg::IRU_IDLE;
            dlv_idx_q <= '0;
            msg_valid_o <= 1'b0;
            msg_o <= '0;
        end else begin
            case (st_q)
                iru_pkg::IRU_IDLE: begin
                    if (|ready_set && !(bus_rd && is_entry(sel_q))) begin
                        dlv_idx_q <= first_set(ready_set);
                        st_q <= iru_pkg::IRU_WAIT;
                    end
                end
                iru_pkg::IRU_WAIT: begin
                    if (pend_clr[dlv_idx_q]) begin
                        st_q <= iru_pkg::IRU_IDLE;
                    end else begin
                        msg_o.dest_logical <= mem_rdata[iru_pkg::B_DMODE];
                        if (mem_rdata[iru_pkg::B_DMODE]) begin
                            msg_o.dest <= mem_rdata[32 + iru_pkg::DEST_LSB +: 8];
                        end else begin
                            msg_o.dest <= {4'h0, mem_rdata[32 + iru_pkg::DEST_LSB +: 4]};
                        end
                        msg_o.mode <= mem_rdata[iru_pkg::MODE_LSB +: 3];
                        msg_o.level <= mem_rdata[iru_pkg::B_TRIG];
                        msg_o.vector <= mem_rdata[iru_pkg::VEC_LSB +: 8];
                        msg_valid_o <= 1'b1;
                        st_q <= iru_pkg::IRU_SEND;
                    end
                end
                iru_pkg::IRU_SEND: begin
                    if (msg_ready_i) begin
                        msg_valid_o <= 1'b0;
                        st_q <= iru_pkg::IRU_IDLE;
                    end
                end
                default: begin
                    st_q <= iru_pkg::IRU_IDLE;
                    msg_valid_o <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_sel_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        sel_wr |=> sel_q == $past(wdata_i[7:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("selector not loaded");

    property p_read_latency;
        @(posedge clk_i) disable iff (!rst_n_i)
        bus_rd |-> ##2 rvalid_o;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read data late");

    property p_partial_ignored;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && addr_i == iru_pkg::DATA_ADDR && be_i != iru_pkg::BE_ALL) |=> $stable(id_q);
    endproperty
    a_partial_ignored: assert property (p_partial_ignored) else $error("partial write took");

    property p_id_reserved;
        @(posedge clk_i) disable iff (!rst_n_i)
        (bus_rd && addr_i == iru_pkg::DATA_ADDR && sel_q == iru_pkg::IDX_ID)
            |-> ##2 (rdata_o[23:0] == 24'h0 && rdata_o[31:28] == 4'h0);
    endproperty
    a_id_reserved: assert property (p_id_reserved) else $error("identifier reserved bits set");

    property p_hi_reserved;
        @(posedge clk_i) disable iff (!rst_n_i)
        (bus_rd && addr_i == iru_pkg::DATA_ADDR && is_entry(sel_q) && sel_q[0])
            |-> ##2 rdata_o[23:0] == 24'h0;
    endproperty
    a_hi_reserved: assert property (p_hi_reserved) else $error("upper half reserved set");

    property p_level_receipt;
        @(posedge clk_i) disable iff (!rst_n_i)
        (|set_lvl) |=> ((irr_q & $past(set_lvl)) == $past(set_lvl));
    endproperty
    a_level_receipt: assert property (p_level_receipt) else $error("receipt not set");

    property p_eoi_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        (|eoi_hit) |=> ((irr_q & $past(eoi_hit) & ~$past(set_lvl)) == '0);
    endproperty
    a_eoi_clear: assert property (p_eoi_clear) else $error("receipt kept after eoi");

    property p_masked_quiet;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == iru_pkg::IRU_IDLE && ready_set == '0) |=> st_q == iru_pkg::IRU_IDLE;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked entry fetched");

    property p_pending_shown;
        @(posedge clk_i) disable iff (!rst_n_i)
        msg_valid_o |-> pend_q[dlv_idx_q];
    endproperty
    a_pending_shown: assert property (p_pending_shown) else $error("message without pending");

    property p_physical_dest;
        @(posedge clk_i) disable iff (!rst_n_i)
        (msg_valid_o && !msg_o.dest_logical) |-> msg_o.dest[7:4] == 4'h0;
    endproperty
    a_physical_dest: assert property (p_physical_dest) else $error("physical dest too wide");
endmodule
`default_nettype wire

/* File: test/iru_msg_sink.sv */
// message sink standing in for the processor local interrupt units
`timescale 1ns/1ps
`default_nettype none
module iru_msg_sink (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic msg_valid_i,
    input wire iru_pkg::iru_msg_t msg_i,
    input wire logic [7:0] stall_i,
    output logic msg_ready_o,
    output logic got_o,
    output var iru_pkg::iru_msg_t last_o
);
    logic [7:0] wait_q;

    ////////////////////////////////////////////////////////////////////////
    // count cycles an offered message has waited
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 8'h00;
        end else if (msg_valid_i && !msg_ready_o) begin
            wait_q <= wait_q + 8'h01;
        end else begin
            wait_q <= 8'h00;
        end
    end

    // accept only once the commanded stall has run out
    assign msg_ready_o = msg_valid_i && (wait_q >= stall_i);

    // record each accepted message for the bench
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            got_o <= 1'b0;
            last_o <= '0;
        end else begin
            got_o <= msg_valid_i && msg_ready_o;
            if (msg_valid_i && msg_ready_o) begin
                last_o <= msg_i;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/io_interrupt_redirection_unit_bench.sv */
// self-checking bench for the interrupt redirection unit
`timescale 1ns/1ps
`default_nettype none
module io_interrupt_redirection_unit_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic rvalid;
    logic [iru_pkg::NUM_ENT-1:0] irq = 24'h0;
    logic eoi_valid = 1'b0;
    logic [7:0] eoi_vector = 8'h00;
    logic msg_valid;
    logic msg_ready;
    iru_pkg::iru_msg_t msg;
    logic [7:0] stall = 8'h00;
    logic got;
    iru_pkg::iru_msg_t last;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    iru_top u_iru_top (
        .clk_i(clk), .rst_n_i(rst_n), .wr_i(wr), .rd_i(rd), .addr_i(addr), .be_i(be),
        .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .irq_i(irq),
        .eoi_valid_i(eoi_valid), .eoi_vector_i(eoi_vector), .msg_valid_o(msg_valid),
        .msg_ready_i(msg_ready), .msg_o(msg)
    );
    iru_msg_sink u_iru_msg_sink (
        .clk_i(clk), .rst_n_i(rst_n), .msg_valid_i(msg_valid), .msg_i(msg),
        .stall_i(stall), .msg_ready_o(msg_ready), .got_o(got), .last_o(last)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            results();
        end
    end

    task automatic results();
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // register bus cycles; wreg writes the data window with all four lanes, bus_wr with the lanes it is given
    task automatic bus_wr(input logic [31:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        be <= b;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        int at;
        at = -1;
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        d = 32'hxxxx_xxxx;
        for (int i = 0; i < 4; i++) begin
            #1;
            if (rvalid === 1'b1) begin
                d = rdata;
                at = i;
            end
            @(posedge clk);
        end
        check("read latency", 32'(at), 32'h1);
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
        bus_wr(iru_pkg::SEL_ADDR, 4'h1, {24'h0, idx});
        bus_wr(iru_pkg::DATA_ADDR, iru_pkg::BE_ALL, d);
    endtask
    task automatic rreg(input logic [7:0] idx, output logic [31:0] d);
        bus_wr(iru_pkg::SEL_ADDR, 4'h1, {24'h0, idx});
        bus_rd(iru_pkg::DATA_ADDR, d);
    endtask
    function automatic logic [31:0] lo(input logic m, input logic t, input logic p,
        input logic dm, input logic [2:0] mode, input logic [7:0] v);
        return {15'h0, m, t, 1'b0, p, 1'b0, dm, mode, v};
    endfunction

    // interrupt side helpers
    task automatic wait_msg(output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            #1;
            if (got === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic fire(input int n, output logic seen);
        @(posedge clk);
        irq[n] <= 1'b1;
        wait_msg(seen);
        @(posedge clk);
        irq[n] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic eoi(input logic [7:0] v);
        @(posedge clk);
        eoi_valid <= 1'b1;
        eoi_vector <= v;
        @(posedge clk);
        eoi_valid <= 1'b0;
    endtask
    task automatic check_msg(input logic [7:0] dest, input logic dl, input logic [2:0] mode,
        input logic [7:0] vec);
        check("msg dest", {24'h0, last.dest}, {24'h0, dest});
        check("msg logical", {31'h0, last.dest_logical}, {31'h0, dl});
        check("msg mode", {29'h0, last.mode}, {29'h0, mode});
        check("msg vector", {24'h0, last.vector}, {24'h0, vec});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        logic [31:0] d;
        bus_rd(iru_pkg::SEL_ADDR, d);
        check("selector", d, 32'h0);
        rreg(iru_pkg::IDX_ID, d);
        check("identifier", d, 32'h0);
        rreg(iru_pkg::IDX_VER, d);
        check("version", d, iru_pkg::VERSION_VAL);
        rreg(iru_pkg::IDX_ARB, d);
        check("arbitration", d, 32'h0);
        for (int n = 0; n < 24; n++) begin
            rreg(8'h10 + 8'(2 * n), d);
            check("entry low", d, 32'h0001_0000);
            rreg(8'h11 + 8'(2 * n), d);
            check("entry high", d, 32'h0);
        end
    endtask

    task automatic t_access();
        logic [31:0] d;
        wreg(iru_pkg::IDX_ID, 32'hffff_ffff);
        rreg(iru_pkg::IDX_ID, d);
        check("identifier", d, 32'h0f00_0000);
        wreg(iru_pkg::IDX_ARB, 32'h0);
        rreg(iru_pkg::IDX_ARB, d);
        check("arbitration", d, 32'h0f00_0000);
        wreg(iru_pkg::IDX_VER, 32'h0);
        rreg(iru_pkg::IDX_VER, d);
        check("version", d, iru_pkg::VERSION_VAL);
        wreg(8'h1d, 32'hffff_ffff);
        rreg(8'h1d, d);
        check("entry high", d, 32'hff00_0000);
        wreg(8'h1c, 32'hffff_ffff);
        rreg(8'h1c, d);
        check("entry low", d, 32'h0001_afff);
        bus_wr(iru_pkg::DATA_ADDR, 4'h7, 32'h0);
        rreg(8'h1c, d);
        check("partial write", d, 32'h0001_afff);
        bus_rd(iru_pkg::SEL_ADDR, d);
        check("selector", d, 32'h0000_001c);
    endtask

    task automatic t_physical();
        logic [31:0] d;
        logic seen;
        wreg(8'h13, 32'ha500_0000);
        wreg(8'h12, lo(1'b0, 1'b0, 1'b0, 1'b0, iru_pkg::MODE_FIXED, 8'h31));
        stall <= 8'h64;
        @(posedge clk);
        irq[1] <= 1'b1;
        repeat (12) @(posedge clk);
        rreg(8'h12, d);
        check("pending", d, 32'h0000_1031);
        stall <= 8'h00;
        wait_msg(seen);
        check("delivered", {31'h0, seen}, 32'h1);
        check_msg(8'h05, 1'b0, iru_pkg::MODE_FIXED, 8'h31);
        @(posedge clk);
        irq[1] <= 1'b0;
        rreg(8'h12, d);
        check("idle", d, 32'h0000_0031);
    endtask

    task automatic t_logical_mask();
        logic seen;
        wreg(8'h15, 32'ha500_0000);
        wreg(8'h14, lo(1'b0, 1'b0, 1'b0, 1'b1, iru_pkg::MODE_LOWEST, 8'h22));
        fire(2, seen);
        check("delivered", {31'h0, seen}, 32'h1);
        check_msg(8'ha5, 1'b1, iru_pkg::MODE_LOWEST, 8'h22);
        check("msg level", {31'h0, last.level}, 32'h0);
        wreg(8'h16, lo(1'b1, 1'b0, 1'b0, 1'b0, iru_pkg::MODE_FIXED, 8'h33));
        fire(3, seen);
        check("masked", {31'h0, seen}, 32'h0);
        wreg(8'h16, lo(1'b0, 1'b0, 1'b0, 1'b0, iru_pkg::MODE_FIXED, 8'h33));
        wait_msg(seen);
        check("lost edge", {31'h0, seen}, 32'h0);
    endtask

    task automatic t_level();
        logic [31:0] d;
        logic seen;
        @(posedge clk);
        irq[4] <= 1'b1;
        wreg(8'h18, lo(1'b0, 1'b1, 1'b1, 1'b0, iru_pkg::MODE_FIXED, 8'h44));
        @(posedge clk);
        irq[4] <= 1'b0;
        wait_msg(seen);
        check("level delivered", {31'h0, seen}, 32'h1);
        check_msg(8'h00, 1'b0, iru_pkg::MODE_FIXED, 8'h44);
        check("msg level", {31'h0, last.level}, 32'h1);
        rreg(8'h18, d);
        check("receipt set", d, 32'h0000_e044);
        @(posedge clk);
        irq[4] <= 1'b1;
        eoi(8'h45);
        rreg(8'h18, d);
        check("receipt kept", d, 32'h0000_e044);
        eoi(8'h44);
        rreg(8'h18, d);
        check("receipt cleared", d, 32'h0000_a044);
    endtask

    task automatic t_modes();
        logic seen;
        for (int m = 0; m < 8; m++) begin
            wreg(8'h1a, lo(1'b0, 1'b0, 1'b0, 1'b0, 3'(m), 8'h50 + 8'(m)));
            fire(5, seen);
            check("message sent", {31'h0, seen}, {31'h0, m != 3 && m != 6});
            if (m != 3 && m != 6) check_msg(8'h00, 1'b0, 3'(m), 8'h50 + 8'(m));
        end
    endtask

    // reset, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_access();
        t_physical();
        t_logical_mask();
        t_level();
        t_modes();
        results();
    end
endmodule
`default_nettype wire
